// file: pleb_pkg.sv
// Package: register map, field positions and reset values for blanking
package pleb_pkg;
  localparam logic [1:0] CTRL_ADDR = 2'h0;
  localparam logic [1:0] AUX_ADDR = 2'h1;
  localparam logic [1:0] DLY_ADDR = 2'h2;
  localparam logic [1:0] STAT_ADDR = 2'h3;
  localparam int HRISE_POS = 15;
  localparam int HFALL_POS = 14;
  localparam int LRISE_POS = 13;
  localparam int LFALL_POS = 12;
  localparam int FLTEN_POS = 11;
  localparam int CLEN_POS = 10;
  localparam int SELH_POS = 5;
  localparam int SELL_POS = 4;
  localparam int HH_POS = 3;
  localparam int HL_POS = 2;
  localparam int LH_POS = 1;
  localparam int LL_POS = 0;
  localparam logic [15:0] CTRL_WMASK = 16'hFC3F;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] AUX_RST = 16'h0000;
  localparam logic [15:0] DLY_RST = 16'h0000;
  localparam int SRC_W = 2;
  typedef struct packed {
    logic fault;
    logic curLimit;
  } pleb_prot_t;
endpackage

// file: pleb_edge_det.sv
// Edge detector for one PWM output
`timescale 1ns/100ps
module pleb_edge_det (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sigIn,
  output logic rise,
  output logic fall
);
  logic prev_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sigIn;
    end
  end
  assign rise = sigIn & ~prev_ff;
  assign fall = ~sigIn & prev_ff;
endmodule

// file: pleb_blank.sv
// Leading-edge and state blanking for one PWM generator channel
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module pleb_blank
  import pleb_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int NSRC = 4
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic pwm_high_side_output,
  input wire logic pwm_low_side_output,
  input wire logic [NSRC-1:0] blankSrc,
  input wire pleb_prot_t protIn,
  output pleb_prot_t protOut,
  output logic blanking
);
  logic [15:0] ctrl_ff;
  logic [SRC_W-1:0] blank_source_select_ff;
  logic [CNT_W-1:0] dly_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic hRise, hFall, lRise, lFall;
  logic edgeTrig, cntActive, stateBlank, selSig;

  pleb_edge_det uHigh (
    .core_clk(core_clk),
    .srst(srst),
    .sigIn(pwm_high_side_output),
    .rise(hRise),
    .fall(hFall)
  );
  pleb_edge_det uLow (
    .core_clk(core_clk),
    .srst(srst),
    .sigIn(pwm_low_side_output),
    .rise(lRise),
    .fall(lFall)
  );

  // Register writes; unimplemented bits never store
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_ff <= CTRL_RST;
      blank_source_select_ff <= AUX_RST[SRC_W-1:0];
      dly_ff <= DLY_RST[CNT_W-1:0];
    end else if (regWr) begin
      if (regAddr == CTRL_ADDR) begin
        ctrl_ff <= regWdata & CTRL_WMASK;
      end else if (regAddr == AUX_ADDR) begin
        blank_source_select_ff <= regWdata[SRC_W-1:0];
      end else if (regAddr == DLY_ADDR) begin
        dly_ff <= regWdata[CNT_W-1:0];
      end
    end
  end

  // Read data one cycle later; zero when no read strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      if (regAddr == CTRL_ADDR) begin
        regRdata <= ctrl_ff & CTRL_WMASK;
      end else if (regAddr == AUX_ADDR) begin
        regRdata <= 16'(blank_source_select_ff);
      end else if (regAddr == DLY_ADDR) begin
        regRdata <= 16'(dly_ff);
      end else begin
        regRdata <= {14'h0, stateBlank, cntActive};
      end
    end else begin
      regRdata <= 16'h0000;
    end
  end

  assign edgeTrig = (ctrl_ff[HRISE_POS] & hRise)
    | (ctrl_ff[HFALL_POS] & hFall)
    | (ctrl_ff[LRISE_POS] & lRise)
    | (ctrl_ff[LFALL_POS] & lFall);

  // Out-of-range select reads low rather than an undefined source
  assign selSig = (32'(blank_source_select_ff) < NSRC) ?
    blankSrc[blank_source_select_ff] : 1'b0;

  assign stateBlank = (ctrl_ff[SELH_POS] & selSig)
    | (ctrl_ff[SELL_POS] & ~selSig)
    | (ctrl_ff[HH_POS] & pwm_high_side_output)
    | (ctrl_ff[HL_POS] & ~pwm_high_side_output)
    | (ctrl_ff[LH_POS] & pwm_low_side_output)
    | (ctrl_ff[LL_POS] & ~pwm_low_side_output);

  assign cntActive = (cnt_ff != '0);

  // Restart loads the delay; a zero delay gives no edge blanking
  always_comb begin
    if (edgeTrig) begin
      nxt_cnt = dly_ff;
    end else if (cntActive) begin
      nxt_cnt = cnt_ff - 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Registered mask adds one cycle of latency to the protected inputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      protOut <= '0;
      blanking <= 1'b0;
    end else begin
      protOut.fault <= protIn.fault & ~stateBlank
        & ~(ctrl_ff[FLTEN_POS] & cntActive);
      protOut.curLimit <= protIn.curLimit & ~stateBlank
        & ~(ctrl_ff[CLEN_POS] & cntActive);
      blanking <= stateBlank | cntActive;
    end
  end

  // Both protected inputs held low in the registered output
  sequence seqMasked;
    !protOut.fault && !protOut.curLimit;
  endsequence

  // Edge blanking in steps: an enabled edge with a nonzero delay loads
  // the counter, which then runs down without a fresh edge
  sequence seqLoad;
    edgeTrig && dly_ff != '0;
  endsequence

  sequence seqCountOn;
    cntActive && !edgeTrig;
  endsequence

  // Control reads carry reserved bits 9:6, as do source select and status reads; the delay register uses them
  AST_RO_ZERO: assert property (
    @(posedge core_clk) disable iff (srst)
    regRd && regAddr == CTRL_ADDR |=> regRdata[9:6] == 4'h0)
    else $error("reserved control bits read nonzero");

  AST_CTRL_MASK: assert property (
    @(posedge core_clk) disable iff (srst)
    regWr && regAddr == CTRL_ADDR |=> ctrl_ff[9:6] == 4'h0)
    else $error("reserved control bits stored");

  AST_CTRL_STORE: assert property (
    @(posedge core_clk) disable iff (srst)
    regWr && regAddr == CTRL_ADDR
      |=> ctrl_ff == ($past(regWdata) & CTRL_WMASK))
    else $error("control write not stored");

  AST_SRC_STORE: assert property (
    @(posedge core_clk) disable iff (srst)
    regWr && regAddr == AUX_ADDR
      |=> blank_source_select_ff == $past(regWdata[SRC_W-1:0]))
    else $error("source select write not stored");

  AST_SRC_RD: assert property (
    @(posedge core_clk) disable iff (srst)
    regRd && regAddr == AUX_ADDR
      |=> regRdata == 16'($past(blank_source_select_ff)))
    else $error("source select read wrong");

  AST_STAT_RD: assert property (
    @(posedge core_clk) disable iff (srst)
    regRd && regAddr == STAT_ADDR
      |=> regRdata[1:0] == $past({stateBlank, cntActive}))
    else $error("status read wrong");

  AST_HRISE: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[HRISE_POS] && hRise && dly_ff != '0 |=> cntActive)
    else $error("high rise did not start counter");

  AST_HFALL: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[HFALL_POS] && hFall |=> cnt_ff == $past(dly_ff))
    else $error("high fall did not load counter");

  AST_LRISE: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[LRISE_POS] && lRise |=> cnt_ff == $past(dly_ff))
    else $error("low rise did not load counter");

  AST_LFALL: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[LFALL_POS] && lFall |=> cnt_ff == $past(dly_ff))
    else $error("low fall did not load counter");

  AST_NO_EDGE: assert property (
    @(posedge core_clk) disable iff (srst)
    !edgeTrig && !cntActive |=> !cntActive)
    else $error("counter started without an enabled edge");

  AST_NOTRIG: assert property (
    @(posedge core_clk) disable iff (srst)
    !edgeTrig && cntActive |=> cnt_ff == $past(cnt_ff) - 1'b1)
    else $error("counter did not count down");

  AST_LOAD_BLANK: assert property (
    @(posedge core_clk) disable iff (srst)
    seqLoad ##1 seqCountOn |=> blanking)
    else $error("blanking flag missing while counting");

  AST_RELEASE: assert property (
    @(posedge core_clk) disable iff (srst)
    cnt_ff == CNT_W'(1) && !edgeTrig |=> !cntActive)
    else $error("counter did not release after last cycle");

  AST_ZERO_DLY: assert property (
    @(posedge core_clk) disable iff (srst)
    edgeTrig && dly_ff == '0 && !cntActive |=> !cntActive)
    else $error("zero delay started the counter");

  AST_FLT_MASK: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[FLTEN_POS] && cntActive |=> !protOut.fault)
    else $error("fault passed during blanking");

  AST_FLT_PASS: assert property (
    @(posedge core_clk) disable iff (srst)
    !ctrl_ff[FLTEN_POS] && !stateBlank
      |=> protOut.fault == $past(protIn.fault))
    else $error("fault masked while blanking off");

  AST_CL_MASK: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[CLEN_POS] && cntActive |=> !protOut.curLimit)
    else $error("current limit passed during blanking");

  AST_CL_PASS: assert property (
    @(posedge core_clk) disable iff (srst)
    !ctrl_ff[CLEN_POS] && !stateBlank
      |=> protOut.curLimit == $past(protIn.curLimit))
    else $error("current limit masked while blanking off");

  AST_SELH: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[SELH_POS] && selSig |=> seqMasked)
    else $error("inputs not masked with source high");

  AST_SELL: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[SELL_POS] && !selSig |=> seqMasked)
    else $error("inputs not masked with source low");

  AST_HH: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[HH_POS] && pwm_high_side_output |=> seqMasked)
    else $error("inputs not masked with high side high");

  AST_HL: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[HL_POS] && !pwm_high_side_output |=> seqMasked)
    else $error("inputs not masked with high side low");

  AST_LH: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[LH_POS] && pwm_low_side_output |=> seqMasked)
    else $error("inputs not masked with low side high");

  AST_LL: assert property (
    @(posedge core_clk) disable iff (srst)
    ctrl_ff[LL_POS] && !pwm_low_side_output |=> seqMasked)
    else $error("inputs not masked with low side low");

  AST_STATE_MASK: assert property (
    @(posedge core_clk) disable iff (srst)
    stateBlank |=> seqMasked)
    else $error("inputs not masked during state blanking");

  AST_PASS_IDLE: assert property (
    @(posedge core_clk) disable iff (srst)
    !stateBlank && !cntActive |=> protOut == $past(protIn))
    else $error("inputs masked with no blanking condition");

  AST_BLANK_FLAG: assert property (
    @(posedge core_clk) disable iff (srst)
    stateBlank || cntActive |=> blanking)
    else $error("blanking flag low while masking");

  AST_BLANK_OFF: assert property (
    @(posedge core_clk) disable iff (srst)
    !stateBlank && !cntActive |=> !blanking)
    else $error("blanking flag high while idle");
endmodule

// file: pleb_pwm_model.sv
// Partner model: PWM outputs, blanking sources and protection inputs
`timescale 1ns/100ps
module pleb_pwm_model
  import pleb_pkg::*;
(
  input wire logic core_clk,
  input wire logic [4:0] lvl,
  output logic pwmH,
  output logic pwmL,
  output logic [3:0] srcOut,
  output pleb_prot_t protOut
);
  // Unselected sources carry the inverse, so a wrong select shows up
  always_ff @(posedge core_clk) begin
    {pwmH, pwmL} <= lvl[4:3];
    srcOut <= {~lvl[2], lvl[2], ~lvl[2], ~lvl[2]};
    protOut <= lvl[1:0];
  end
endmodule

// file: pwm_leading_edge_blanking_tb.sv
// Testbench: register access, state blanking and edge blanking
`timescale 1ns/100ps
module pwm_leading_edge_blanking_tb
  import pleb_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic [4:0] lvl = 5'h03;
  logic pwmH, pwmL, blanking;
  logic [3:0] src;
  pleb_prot_t protIn, protOut;
  int nMismatch = 0;
  int checks = 0;
  always #50 core_clk = ~core_clk;
  pleb_pwm_model i_pleb_pwm_model (.core_clk, .lvl, .pwmH, .pwmL,
    .srcOut(src), .protOut(protIn));
  pleb_blank #(.NSRC(4)) i_pleb_blank (.core_clk, .srst, .regAddr,
    .regWdata, .regWr, .regRd, .regRdata, .pwm_high_side_output(pwmH),
    .pwm_low_side_output(pwmL), .blankSrc(src), .protIn, .protOut,
    .blanking);
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    cyc(1);
    regWr <= 1'b0;
    cyc(1);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    cyc(1);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
    cyc(1);
  endtask
  task automatic obs(input logic b, input logic [1:0] p);
    #1 chk({15'h0, blanking}, {15'h0, b});
    chk({14'h0, protOut}, {14'h0, p});
    cyc(1);
  endtask
  task automatic st(input logic [15:0] c, input logic [2:0] hls,
                    input logic b);
    wr(CTRL_ADDR, c);
    lvl <= {hls, 2'b11};
    cyc(5);
    obs(b, b ? 2'b00 : 2'b11);
    rd(STAT_ADDR, {14'h0, b, 1'b0});
  endtask
  // Edges 0..3: high rise, high fall, low rise, low fall
  task automatic eg(input int i);
    logic [4:0] m;
    logic [4:0] prep;
    m = (i < 2) ? 5'h10 : 5'h08;
    prep = i[0] ? (m | 5'h03) : 5'h03;
    wr(CTRL_ADDR, (16'h8000 >> i) | (i[0] ? 16'h0400 : 16'h0800));
    lvl <= prep;
    cyc(14);
    lvl <= prep ^ m;
    cyc(5);
    obs(1'b1, i[0] ? 2'b10 : 2'b01);
    rd(STAT_ADDR, 16'h0001);
    cyc(2);
    obs(1'b1, i[0] ? 2'b10 : 2'b01);
    obs(1'b0, 2'b11);
    lvl <= prep;
    cyc(5);
    obs(1'b0, 2'b11);
  endtask
  task automatic test_done;
    if (nMismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(2);
    srst <= 1'b0;
    cyc(1);
    rd(CTRL_ADDR, 16'h0000);
    wr(CTRL_ADDR, 16'hFFFF);
    rd(CTRL_ADDR, 16'hFC3F);
    wr(AUX_ADDR, 16'h0002);
    wr(DLY_ADDR, 16'h0008);
    rd(AUX_ADDR, 16'h0002);
    rd(DLY_ADDR, 16'h0008);
    st(16'h0008, 3'b100, 1'b1);
    st(16'h0008, 3'b010, 1'b0);
    st(16'h0004, 3'b010, 1'b1);
    st(16'h0004, 3'b100, 1'b0);
    st(16'h0002, 3'b110, 1'b1);
    st(16'h0002, 3'b100, 1'b0);
    st(16'h0001, 3'b100, 1'b1);
    st(16'h0001, 3'b110, 1'b0);
    st(16'h0020, 3'b001, 1'b1);
    st(16'h0020, 3'b000, 1'b0);
    st(16'h0010, 3'b000, 1'b1);
    st(16'h0010, 3'b001, 1'b0);
    st(16'h000A, 3'b010, 1'b1);
    st(16'h000A, 3'b000, 1'b0);
    for (int i = 0; i < 4; i++) eg(i);
    test_done;
  end
  // Tests need about 300 cycles; the margin covers slow blanking paths
  initial begin
    cyc(4000);
    nMismatch++;
    test_done;
  end
endmodule
